// *** dsadc_sequencer.sv ***
// Contract
// - LCD backplane is oscillator divided by 800
// - Segments toggle with backplane, inverted when lit
// - Polarity indicator lit for negative input
// - Count clock is oscillator divided by four
// - Integrate lasts exactly 1000 counts
// - Deintegrate counts up to 2000, result latched
// - Auto-zero absorbs unused deintegrate counts
// - Every cycle totals 4000 counts, 16000 clocks
// - LED variant: static sinking segments, no backplane
// - Phases repeat auto-zero, integrate, deintegrate
// - Polarity captured at integrate end selects reference
// - Lamp test lights all segments, shows 1888
// - Over-range blanks three low digits
`timescale 1ns/100ps
`default_nettype none
module dsadc_sequencer (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        led_mode,
  input  wire logic        comp_out,
  input  wire logic        lamp_test,
  output logic             az_sw,
  output logic             int_sw,
  output logic             deint_sw,
  output logic             ref_neg,
  output logic             backplane_drive,
  output logic [6:0]       seg_ones,
  output logic [6:0]       seg_tens,
  output logic [6:0]       seg_hund,
  output logic [1:0]       seg_thou,
  output logic             seg_minus,
  output logic             over_range,
  output logic [10:0]      result_count
);
  logic [1:0]                 div_r;
  logic [11:0]                cyc_r;
  logic [11:0]                ph_cnt_r;
  dsadc_pkg::dsadc_phase_t    phase_r;
  dsadc_pkg::dsadc_phase_t    phase_nxt;
  logic                       neg_r;
  logic [3:0]                 d0_r;
  logic [3:0]                 d1_r;
  logic [3:0]                 d2_r;
  logic                       d3_r;
  logic [3:0]                 l0_r;
  logic [3:0]                 l1_r;
  logic [3:0]                 l2_r;
  logic                       l3_r;
  logic                       ovr_r;
  logic                       lneg_r;
  logic [9:0]                 bp_cnt_r;
  logic                       bp_r;

  wire logic count_tick = (div_r == dsadc_pkg::CLK_DIV_LAST);
  wire logic int_done   = (ph_cnt_r == dsadc_pkg::INT_COUNTS - 12'h001);
  wire logic deint_full = (ph_cnt_r == dsadc_pkg::DEINT_MAX - 12'h001);
  // The comparator flips when the integrator crosses zero back toward its start
  wire logic zero_cross = (comp_out != neg_r);
  wire logic deint_end  = zero_cross | deint_full;
  wire logic cyc_end    = (cyc_r == dsadc_pkg::CYCLE_COUNTS - 12'h001);

  function automatic logic [3:0] dec_inc(input logic [3:0] d);
    dec_inc = (d == dsadc_pkg::DIGIT_MAX) ? 4'h0 : d + 4'h1;
  endfunction

  // Auto-zero ends only on the cycle boundary, so it takes the unused deintegrate counts
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      dsadc_pkg::DSADC_AUTO_ZERO:   if (cyc_end) phase_nxt = dsadc_pkg::DSADC_INTEGRATE;
      dsadc_pkg::DSADC_INTEGRATE:   if (int_done) phase_nxt = dsadc_pkg::DSADC_DEINTEGRATE;
      dsadc_pkg::DSADC_DEINTEGRATE: if (deint_end) phase_nxt = dsadc_pkg::DSADC_AUTO_ZERO;
      default:                      phase_nxt = dsadc_pkg::DSADC_AUTO_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cyc_r    <= dsadc_pkg::CYCLE_COUNTS - dsadc_pkg::AZ_MIN_COUNTS;
      ph_cnt_r <= 12'h000;
      phase_r  <= dsadc_pkg::DSADC_AUTO_ZERO;
    end else if (count_tick) begin
      cyc_r    <= cyc_end ? 12'h000 : cyc_r + 12'h001;
      ph_cnt_r <= (phase_nxt != phase_r) ? 12'h000 : ph_cnt_r + 12'h001;
      phase_r  <= phase_nxt;
    end
  end

  // Input polarity sampled on the last integrate count
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      neg_r <= 1'b0;
    end else if (count_tick && phase_r == dsadc_pkg::DSADC_INTEGRATE && int_done) begin
      neg_r <= comp_out;
    end
  end

  // BCD counters run during deintegrate, held cleared in the other phases
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      d0_r <= 4'h0;
      d1_r <= 4'h0;
      d2_r <= 4'h0;
      d3_r <= 1'b0;
    end else if (count_tick) begin
      if (phase_r != dsadc_pkg::DSADC_DEINTEGRATE) begin
        d0_r <= 4'h0;
        d1_r <= 4'h0;
        d2_r <= 4'h0;
        d3_r <= 1'b0;
      end else if (!deint_end) begin
        d0_r <= dec_inc(d0_r);
        if (d0_r == dsadc_pkg::DIGIT_MAX) begin
          d1_r <= dec_inc(d1_r);
          if (d1_r == dsadc_pkg::DIGIT_MAX) begin
            d2_r <= dec_inc(d2_r);
            if (d2_r == dsadc_pkg::DIGIT_MAX) begin
              d3_r <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Result latched once per conversion; display holds between conversions
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      l0_r   <= 4'h0;
      l1_r   <= 4'h0;
      l2_r   <= 4'h0;
      l3_r   <= 1'b0;
      ovr_r  <= 1'b0;
      lneg_r <= 1'b0;
    end else if (count_tick && phase_r == dsadc_pkg::DSADC_DEINTEGRATE && deint_end) begin
      l0_r   <= d0_r;
      l1_r   <= d1_r;
      l2_r   <= d2_r;
      l3_r   <= d3_r;
      ovr_r  <= !zero_cross;
      lneg_r <= neg_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bp_cnt_r <= 10'h000;
      bp_r     <= 1'b0;
    end else if (bp_cnt_r == dsadc_pkg::BP_HALF_LAST) begin
      bp_cnt_r <= 10'h000;
      bp_r     <= !bp_r;
    end else begin
      bp_cnt_r <= bp_cnt_r + 10'h001;
    end
  end

  logic [6:0] dec0;
  logic [6:0] dec1;
  logic [6:0] dec2;

  dsadc_seg_decode u_dec0 (.digit(l0_r), .segs(dec0));
  dsadc_seg_decode u_dec1 (.digit(l1_r), .segs(dec1));
  dsadc_seg_decode u_dec2 (.digit(l2_r), .segs(dec2));

  wire logic [6:0] lit0  = lamp_test ? dsadc_pkg::SEG_EIGHT :
                           ovr_r ? dsadc_pkg::SEG_BLANK : dec0;
  wire logic [6:0] lit1  = lamp_test ? dsadc_pkg::SEG_EIGHT :
                           ovr_r ? dsadc_pkg::SEG_BLANK : dec1;
  wire logic [6:0] lit2  = lamp_test ? dsadc_pkg::SEG_EIGHT :
                           ovr_r ? dsadc_pkg::SEG_BLANK : dec2;
  wire logic [1:0] lit3  = (lamp_test | l3_r | ovr_r) ? dsadc_pkg::SEG_ONE[2:1] : 2'h0;
  wire logic       litm  = lamp_test | lneg_r;
  // Lamp test holds DC on an LCD; long use can damage the glass
  wire logic       bp_nx = bp_r & !lamp_test;
  wire logic       drv   = led_mode ? 1'b0 : bp_nx;
  // LED mode: output high means sink on; LCD mode: lit XOR backplane
  wire logic       inv   = led_mode ? 1'b0 : bp_nx;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      az_sw           <= 1'b1;
      int_sw          <= 1'b0;
      deint_sw        <= 1'b0;
      ref_neg         <= 1'b0;
      backplane_drive <= 1'b0;
      seg_ones        <= 7'h00;
      seg_tens        <= 7'h00;
      seg_hund        <= 7'h00;
      seg_thou        <= 2'h0;
      seg_minus       <= 1'b0;
      over_range      <= 1'b0;
      result_count    <= 11'h000;
    end else begin
      az_sw           <= (phase_r == dsadc_pkg::DSADC_AUTO_ZERO);
      int_sw          <= (phase_r == dsadc_pkg::DSADC_INTEGRATE);
      deint_sw        <= (phase_r == dsadc_pkg::DSADC_DEINTEGRATE);
      ref_neg         <= !neg_r;
      backplane_drive <= drv;
      seg_ones        <= lit0 ^ {7{inv}};
      seg_tens        <= lit1 ^ {7{inv}};
      seg_hund        <= lit2 ^ {7{inv}};
      seg_thou        <= lit3 ^ {2{inv}};
      seg_minus       <= litm ^ inv;
      over_range      <= ovr_r;
      result_count    <= 11'(({7'h00, l3_r} * 11'h3e8) + (l2_r * 11'h064)
                         + (l1_r * 11'h00a) + l0_r);
    end
  end
endmodule
`default_nettype wire

// *** dsadc_pkg.sv ***
package dsadc_pkg;
  localparam logic [1:0]  CLK_DIV_LAST   = 2'h3;      // Oscillator divided by four
  localparam logic [11:0] INT_COUNTS     = 12'h3e8;   // 1000 counts
  localparam logic [11:0] DEINT_MAX      = 12'h7d0;   // 2000 counts
  localparam logic [11:0] AZ_MIN_COUNTS  = 12'h3e8;   // 1000 counts
  localparam logic [11:0] CYCLE_COUNTS   = 12'hfa0;   // 4000 counts per measurement
  localparam logic [9:0]  BP_HALF_LAST   = 10'h18f;   // 400 oscillator clocks per half
  localparam logic [6:0]  SEG_BLANK      = 7'h00;
  localparam logic [6:0]  SEG_EIGHT      = 7'h7f;
  localparam logic [6:0]  SEG_ONE        = 7'h06;
  localparam logic [3:0]  DIGIT_MAX      = 4'h9;

  typedef enum logic [1:0] {
    DSADC_AUTO_ZERO,
    DSADC_INTEGRATE,
    DSADC_DEINTEGRATE
  } dsadc_phase_t;
endpackage

// *** dsadc_seg_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
// Digit to segments, bit order g f e d c b a
module dsadc_seg_decode (
  input  wire logic [3:0] digit,
  output logic      [6:0] segs
);
  always_comb begin
    case (digit)
      4'h0:    segs = 7'h3f;
      4'h1:    segs = 7'h06;
      4'h2:    segs = 7'h5b;
      4'h3:    segs = 7'h4f;
      4'h4:    segs = 7'h66;
      4'h5:    segs = 7'h6d;
      4'h6:    segs = 7'h7d;
      4'h7:    segs = 7'h07;
      4'h8:    segs = 7'h7f;
      4'h9:    segs = 7'h6f;
      default: segs = 7'h00;
    endcase
  end
endmodule
`default_nettype wire

// *** dsadc_sequencer_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module dsadc_sequencer_sva (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       led_mode,
  input wire logic       lamp_test,
  input wire logic       az_sw,
  input wire logic       int_sw,
  input wire logic       deint_sw,
  input wire logic       backplane_drive,
  input wire logic [6:0] seg_ones,
  input wire logic [1:0] seg_thou
);
  logic [13:0] ph_r;
  logic [14:0] cyc_r;
  logic [9:0]  bp_r;
  logic        seen_r;
  logic        mode_q_r;
  // Cycles since the last phase change, cycle start and backplane edge
  always_ff @(posedge sys_clk) begin
    ph_r   <= !nrst ? 14'h0 : $changed({az_sw, int_sw, deint_sw}) ? 14'h1 : ph_r + 14'h1;
    cyc_r  <= !nrst ? 15'h0 : $rose(int_sw) ? 15'h1 : cyc_r + 15'h1;
    seen_r <= nrst && (seen_r || $rose(int_sw));
    // The backplane output lags a mode change by one register stage
    mode_q_r <= led_mode || lamp_test;
    bp_r   <= (!nrst || led_mode || lamp_test || mode_q_r || $changed(backplane_drive)) ?
              10'h0 : bp_r + 10'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_az_end;  $fell(az_sw);  endsequence
  sequence s_int_end; $fell(int_sw); endsequence
  a_phase_onehot: assert property ($onehot({az_sw, int_sw, deint_sw}))
    else $error("phase controls not one-hot");
  a_order_int: assert property (s_az_end |-> int_sw)
    else $error("integrate does not follow auto-zero");
  a_order_deint: assert property (s_int_end |-> deint_sw)
    else $error("deintegrate does not follow integrate");
  a_int_length: assert property (s_int_end |-> ph_r == 14'h0fa0)
    else $error("integrate length wrong");
  a_deint_max: assert property ($fell(deint_sw) |-> ph_r <= 14'h1f40)
    else $error("deintegrate too long");
  a_cycle_total: assert property ($rose(int_sw) && seen_r |-> cyc_r == 15'h3e80)
    else $error("cycle length wrong");
  a_bp_period: assert property (!led_mode && !lamp_test |-> bp_r <= 10'h190)
    else $error("backplane half period too long");
  a_led_static: assert property (led_mode && $past(led_mode) |-> !backplane_drive)
    else $error("backplane driven in LED mode");
  a_lamp_all: assert property (lamp_test && $past(lamp_test) |->
    seg_ones == 7'h7f && seg_thou == 2'h3)
    else $error("lamp test not all lit");
endmodule
`default_nettype wire

// *** dsadc_analog_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dsadc_analog_model (
  input  wire logic        sys_clk,
  input  wire logic        deint_sw,
  input  wire logic [11:0] target,
  input  wire logic        neg,
  output logic             comp_out
);
  logic [13:0] cnt_r = 14'h0;
  // Zero cross after target count ticks; never within 2000 for over-range
  always @(posedge sys_clk) begin
    cnt_r    <= deint_sw ? cnt_r + 14'h1 : 14'h0;
    comp_out <= (deint_sw && cnt_r >= {target, 2'h0}) ? !neg : neg;
  end
endmodule
`default_nettype wire

// *** tb_dual_slope_adc_sequencer_display.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_dual_slope_adc_sequencer_display;
  logic sys_clk, nrst, led_mode, lamp_test, comp_out, neg;
  logic az_sw, int_sw, deint_sw, ref_neg, backplane_drive, seg_minus, over_range;
  logic [6:0]  seg_ones, seg_tens, seg_hund;
  logic [1:0]  seg_thou;
  logic [10:0] result_count;
  logic [11:0] tgt;
  int          n_errors, compares, cyc;
  dsadc_sequencer dut_u (.sys_clk(sys_clk), .nrst(nrst), .led_mode(led_mode),
    .comp_out(comp_out), .lamp_test(lamp_test), .az_sw(az_sw), .int_sw(int_sw),
    .deint_sw(deint_sw), .ref_neg(ref_neg), .backplane_drive(backplane_drive),
    .seg_ones(seg_ones), .seg_tens(seg_tens), .seg_hund(seg_hund), .seg_thou(seg_thou),
    .seg_minus(seg_minus), .over_range(over_range), .result_count(result_count));
  dsadc_analog_model model_u (.sys_clk(sys_clk), .deint_sw(deint_sw), .target(tgt),
    .neg(neg), .comp_out(comp_out));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Sets the analog target, then runs one full conversion on it
  task automatic conv(input logic [11:0] k, input logic n);
    tgt <= k;
    neg <= n;
    @(posedge sys_clk iff int_sw);
    @(posedge sys_clk iff deint_sw);
    repeat (2) @(posedge sys_clk);
    check(ref_neg, !n);
    @(posedge sys_clk iff !deint_sw);
    repeat (4) @(posedge sys_clk);
    check(seg_minus, n);
    check(over_range, k > 12'h7d0);
    if (k <= 12'h7d0) check(result_count + 11'h1 - k[10:0] <= 11'h2, 1'b1);
  endtask
  task automatic t_pos;
    conv(12'h22b, 1'b0);
    check(seg_tens, 7'h6d);
    check(seg_hund, 7'h6d);
    check(seg_thou, 2'h0);
  endtask
  task automatic t_neg;
    conv(12'h613, 1'b1);
    check(seg_thou, 2'h3);
    check(seg_hund, 7'h6d);
  endtask
  task automatic t_over;
    conv(12'h9c4, 1'b0);
    check(seg_thou, 2'h3);
    check({seg_ones, seg_tens}, 14'h0);
    check(seg_hund, 7'h00);
  endtask
  task automatic t_lcd;
    int n;
    led_mode <= 1'b0;
    @(posedge sys_clk iff backplane_drive);
    @(posedge sys_clk iff !backplane_drive);
    n = 0;
    while (!backplane_drive) begin
      n++;
      @(posedge sys_clk);
    end
    check(n, 400);
    repeat (10) @(posedge sys_clk);
    check(seg_tens ^ {7{backplane_drive}}, 7'h6d);
    led_mode <= 1'b1;
  endtask
  task automatic t_lamp;
    lamp_test <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check({seg_ones, seg_tens}, 14'h3fff);
    check(seg_minus, 1'b1);
    lamp_test <= 1'b0;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    nrst = 1'b0;
    led_mode = 1'b1;
    lamp_test = 1'b0;
    tgt = 12'h0;
    neg = 1'b0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    t_pos;
    t_neg;
    t_lcd;
    t_over;
    t_lamp;
    test_done;
  end
endmodule
bind dsadc_sequencer dsadc_sequencer_sva chk_u (.sys_clk(sys_clk), .nrst(nrst),
  .led_mode(led_mode), .lamp_test(lamp_test), .az_sw(az_sw), .int_sw(int_sw),
  .deint_sw(deint_sw), .backplane_drive(backplane_drive), .seg_ones(seg_ones),
  .seg_thou(seg_thou));
`default_nettype wire
